// ===== common/host_port_pkg.sv
package host_port_pkg;

	// ==========================================
	// Serial addressing
	localparam logic [5:0] MAIN_ADDR_HIGH = 6'h20;
	localparam logic [7:0] REVISION_VALUE = 8'h0000_0005; // Arbitrary value

	// ==========================================
	// Register map, one byte each
	localparam logic [7:0] REG_REVISION = 8'h0000_00EA;
	localparam logic [7:0] REG_PROC_MAP = 8'h0000_00FD;
	localparam logic [7:0] REG_SCRATCH = 8'h0000_00FE;
	localparam logic [7:0] PROC_MAP_RESET = 8'h0000_0000;
	localparam logic [7:0] SCRATCH_RESET = 8'h0000_0000;
	localparam logic [7:0] READ_IDLE = 8'h0000_00FF;

	// ==========================================
	// Bit counting
	localparam logic [3:0] BIT_LAST = 4'h0007;
	localparam logic [3:0] BIT_ACK = 4'h0008;
	localparam logic [3:0] BIT_ZERO = 4'h0000;

	// ==========================================
	// Pin and register file groups
	typedef struct packed {
		logic clk;
		logic data;
	} serial_pins_type;

	typedef struct packed {
		logic [7:0] procMap;
		logic [7:0] scratch;
	} reg_file_type;

endpackage

// ===== core/host_control_port.sv
// Operation
// - No acknowledge while port select is high or hardware reset is low.
// - Register access only after reset is released and select is low.
// - Hardware reset returns every writable register to its default.
// - Read-only revision register in the main map identifies the part.
// - Address low bit pin sets the main map slave address low bit.
// - Slave samples the serial pins on ref_clk, so that clock must be running.
`timescale 1ns/1ns
`default_nettype none

module host_control_port (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Device pins
	input wire logic hwReset_n,
	input wire logic portSelect_n,
	input wire logic address_low_bit_pin,
	// Serial bus, open drain
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOe_n,
	// Register contents
	output logic [7:0] processor_map_address
);

	typedef enum {IDLE, ADDR, ACK_ADDR, WRITE, ACK_WRITE, READ, READ_ACK}
		state_type;

	// ==========================================
	// Pin synchronisers
	host_port_pkg::serial_pins_type pinMeta_r, pinSync_r, pinPrev_r;
	logic [1:0] ctlMeta_r, ctlSync_r;
	logic addrPinMeta_r, addrPinSync_r;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pinMeta_r <= '1;
			pinSync_r <= '1;
			pinPrev_r <= '1;
			ctlMeta_r <= 2'b01;
			ctlSync_r <= 2'b01;
			addrPinMeta_r <= 1'b0;
			addrPinSync_r <= 1'b0;
		end else begin
			pinMeta_r <= '{clk: sclIn, data: sdaIn};
			pinSync_r <= pinMeta_r;
			pinPrev_r <= pinSync_r;
			ctlMeta_r <= {hwReset_n, portSelect_n};
			ctlSync_r <= ctlMeta_r;
			addrPinMeta_r <= address_low_bit_pin;
			addrPinSync_r <= addrPinMeta_r;
		end
	end

	// Edge and bus condition detect
	logic sclRise, sclFall, startCond, stopCond, portOn;
	assign sclRise = pinSync_r.clk && !pinPrev_r.clk;
	assign sclFall = !pinSync_r.clk && pinPrev_r.clk;
	assign startCond = pinSync_r.clk && pinPrev_r.clk && pinPrev_r.data
		&& !pinSync_r.data;
	assign stopCond = pinSync_r.clk && pinPrev_r.clk && !pinPrev_r.data
		&& pinSync_r.data;
	assign portOn = ctlSync_r[1] && !ctlSync_r[0];

	// ==========================================
	// Slave state
	state_type state_r, state_nxt;
	logic [3:0] bitCnt_r, bitCnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] regPtr_r, regPtr_nxt;
	logic ptrSet_r, ptrSet_nxt;
	logic sdaOe_n_r, sdaOe_n_nxt;
	host_port_pkg::reg_file_type regs_r, regs_nxt;

	function automatic logic [7:0] readReg(input logic [7:0] ptr,
		input host_port_pkg::reg_file_type rf);
		unique case (ptr)
			host_port_pkg::REG_REVISION: readReg = host_port_pkg::REVISION_VALUE;
			host_port_pkg::REG_PROC_MAP: readReg = rf.procMap;
			host_port_pkg::REG_SCRATCH: readReg = rf.scratch;
			default: readReg = host_port_pkg::READ_IDLE;
		endcase
	endfunction

	always_comb begin
		state_nxt = state_r;
		bitCnt_nxt = bitCnt_r;
		shift_nxt = shift_r;
		regPtr_nxt = regPtr_r;
		ptrSet_nxt = ptrSet_r;
		sdaOe_n_nxt = sdaOe_n_r;
		regs_nxt = regs_r;
		if (!portOn) begin
			state_nxt = IDLE;
			sdaOe_n_nxt = 1'b1;
		end else if (startCond) begin
			state_nxt = ADDR;
			bitCnt_nxt = host_port_pkg::BIT_ZERO;
			ptrSet_nxt = 1'b0;
			sdaOe_n_nxt = 1'b1;
		end else if (stopCond) begin
			state_nxt = IDLE;
			sdaOe_n_nxt = 1'b1;
		end else begin
			unique case (state_r)
				IDLE: ;
				ADDR, WRITE: if (sclRise) begin
					shift_nxt = {shift_r[6:0], pinSync_r.data};
					bitCnt_nxt = bitCnt_r + 4'h0001;
				end else if (sclFall && bitCnt_r == host_port_pkg::BIT_ACK) begin
					bitCnt_nxt = host_port_pkg::BIT_ZERO;
					if (state_r == ADDR) begin
						if (shift_r[7:1] == {host_port_pkg::MAIN_ADDR_HIGH,
							addrPinSync_r}) begin
							state_nxt = ACK_ADDR;
							sdaOe_n_nxt = 1'b0;
						end else begin
							state_nxt = IDLE;
						end
					end else begin
						state_nxt = ACK_WRITE;
						sdaOe_n_nxt = 1'b0;
						if (!ptrSet_r) begin
							regPtr_nxt = shift_r;
							ptrSet_nxt = 1'b1;
						end else begin
							if (regPtr_r == host_port_pkg::REG_PROC_MAP)
								regs_nxt.procMap = shift_r;
							if (regPtr_r == host_port_pkg::REG_SCRATCH)
								regs_nxt.scratch = shift_r;
							regPtr_nxt = regPtr_r + 8'h0001;
						end
					end
				end
				ACK_ADDR, ACK_WRITE: if (sclFall) begin
					if (state_r == ACK_ADDR && shift_r[0]) begin
						state_nxt = READ;
						shift_nxt = readReg(regPtr_r, regs_r);
						sdaOe_n_nxt = shift_nxt[7];
						regPtr_nxt = regPtr_r + 8'h0001;
						bitCnt_nxt = host_port_pkg::BIT_ZERO;
					end else begin
						state_nxt = WRITE;
						sdaOe_n_nxt = 1'b1;
					end
				end
				READ: if (sclFall) begin
					if (bitCnt_r == host_port_pkg::BIT_LAST) begin
						state_nxt = READ_ACK;
						sdaOe_n_nxt = 1'b1;
					end else begin
						shift_nxt = {shift_r[6:0], 1'b0};
						sdaOe_n_nxt = shift_r[6];
						bitCnt_nxt = bitCnt_r + 4'h0001;
					end
				end
				READ_ACK: if (sclRise && pinSync_r.data) begin
					state_nxt = IDLE;
				end else if (sclFall) begin
					state_nxt = READ;
					shift_nxt = readReg(regPtr_r, regs_r);
					sdaOe_n_nxt = shift_nxt[7];
					regPtr_nxt = regPtr_r + 8'h0001;
					bitCnt_nxt = host_port_pkg::BIT_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= IDLE;
			bitCnt_r <= host_port_pkg::BIT_ZERO;
			shift_r <= host_port_pkg::PROC_MAP_RESET;
			regPtr_r <= host_port_pkg::PROC_MAP_RESET;
			ptrSet_r <= 1'b0;
			sdaOe_n_r <= 1'b1;
			regs_r <= '{procMap: host_port_pkg::PROC_MAP_RESET,
				scratch: host_port_pkg::SCRATCH_RESET};
		end else if (!ctlSync_r[1]) begin
			state_r <= IDLE;
			sdaOe_n_r <= 1'b1;
			ptrSet_r <= 1'b0;
			regs_r <= '{procMap: host_port_pkg::PROC_MAP_RESET,
				scratch: host_port_pkg::SCRATCH_RESET};
		end else begin
			state_r <= state_nxt;
			bitCnt_r <= bitCnt_nxt;
			shift_r <= shift_nxt;
			regPtr_r <= regPtr_nxt;
			ptrSet_r <= ptrSet_nxt;
			sdaOe_n_r <= sdaOe_n_nxt;
			regs_r <= regs_nxt;
		end
	end

	assign sdaOe_n = sdaOe_n_r;
	assign processor_map_address = regs_r.procMap;

	// ==========================================
	// Checks
	a_no_ack_unselected: assert property (@(posedge ref_clk) disable iff (reset)
		!portOn |=> sdaOe_n) else $error("Driven while deselected");
	a_reset_clears_map: assert property (@(posedge ref_clk) disable iff (reset)
		!ctlSync_r[1] |=>
		processor_map_address == host_port_pkg::PROC_MAP_RESET)
		else $error("Map address not cleared");
	a_idle_when_off: assert property (@(posedge ref_clk) disable iff (reset)
		!ctlSync_r[0] ##0 !portOn |=> state_r == IDLE)
		else $error("Active while off");
	a_ack_addr_match: assert property (@(posedge ref_clk) disable iff (reset)
		state_r == ADDR && state_nxt == ACK_ADDR |->
		shift_r[1] == addrPinSync_r)
		else $error("Wrong address acknowledged");
	a_ack_drives_low: assert property (@(posedge ref_clk) disable iff (reset)
		state_r inside {ACK_ADDR, ACK_WRITE} |-> !sdaOe_n)
		else $error("Ack not driven");
	a_revision_const: assert property (@(posedge ref_clk) disable iff (reset)
		state_r != READ && state_nxt == READ
		&& regPtr_r == host_port_pkg::REG_REVISION |=>
		shift_r == host_port_pkg::REVISION_VALUE)
		else $error("Revision changed");
	a_write_stable: assert property (@(posedge ref_clk) disable iff (reset)
		ctlSync_r[1] && state_r != WRITE |=> $stable(processor_map_address))
		else $error("Map address changed outside write");
	a_stop_idles: assert property (@(posedge ref_clk) disable iff (reset)
		portOn && stopCond && !startCond && ctlSync_r[1] |=> state_r == IDLE)
		else $error("Stop not honoured");

endmodule
`default_nettype wire

// ===== dv/host_master_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Board side serial bus master
module host_master_model (
	// Clock
	input wire logic ref_clk,
	// Serial bus
	input wire logic sdaLine,
	output logic sclOut,
	output logic sdaOut
);
	initial begin
		sclOut = 1'b1;
		sdaOut = 1'b1;
	end

	task automatic hp();
		repeat (10) @(negedge ref_clk);
	endtask

	task automatic bitIo(input logic v, output logic s);
		sdaOut = v;
		hp();
		sclOut = 1'b1;
		hp();
		s = sdaLine;
		sclOut = 1'b0;
		hp();
	endtask

	task automatic start();
		sdaOut = 1'b1;
		hp();
		sclOut = 1'b1;
		hp();
		sdaOut = 1'b0;
		hp();
		sclOut = 1'b0;
		hp();
	endtask

	task automatic stop();
		sdaOut = 1'b0;
		hp();
		sclOut = 1'b1;
		hp();
		sdaOut = 1'b1;
		hp();
	endtask

	// Sends b MSB first, m is the master's ninth bit
	task automatic xbyte(input logic [7:0] b, input logic m,
		output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(b[i], s);
			r[i] = s;
		end
		bitIo(m, s);
		ack = ~s;
	endtask
endmodule

`default_nettype wire

// ===== dv/video_part_host_control_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module video_part_host_control_port_tb_top;
	// ==========================================
	// Pins and bus
	localparam int RESET_PULSE = 50; // Shortened pulse
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic hwReset_n = 1'b1;
	logic portSelect_n = 1'b0;
	logic address_low_bit_pin = 1'b0;
	logic sclOut;
	logic sdaOut;
	logic sdaOe_n;
	logic [7:0] processor_map_address;
	wire logic sdaLine = sdaOut & sdaOe_n;
	int bad_count = 0;
	int compares = 0;
	int procMap = 0;
	int scratch = 0;
	logic [7:0] r;
	logic a;
	logic [31:0] rv;

	always #2 ref_clk = ~ref_clk;

	host_control_port host_control_port_inst (
		.ref_clk(ref_clk),
		.reset(reset),
		.hwReset_n(hwReset_n),
		.portSelect_n(portSelect_n),
		.address_low_bit_pin(address_low_bit_pin),
		.sclIn(sclOut),
		.sdaIn(sdaLine),
		.sdaOe_n(sdaOe_n),
		.processor_map_address(processor_map_address)
	);

	host_master_model host_master_model_inst (
		.ref_clk(ref_clk),
		.sdaLine(sdaLine),
		.sclOut(sclOut),
		.sdaOut(sdaOut)
	);

	// ==========================================
	// Compares and model
	task automatic chkAck(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask

	task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] model(input logic [7:0] p);
		case (p)
			host_port_pkg::REG_REVISION: return host_port_pkg::REVISION_VALUE;
			host_port_pkg::REG_PROC_MAP: return procMap[7:0];
			host_port_pkg::REG_SCRATCH: return scratch[7:0];
			default: return host_port_pkg::READ_IDLE;
		endcase
	endfunction

	task automatic access(input logic [6:0] dev, input logic [7:0] p,
		input logic [7:0] d, input logic rd);
		logic e;
		e = !portSelect_n && hwReset_n
			&& dev == {host_port_pkg::MAIN_ADDR_HIGH, address_low_bit_pin};
		host_master_model_inst.start();
		host_master_model_inst.xbyte({dev, 1'b0}, 1'b1, r, a);
		chkAck(a, e);
		if (e) begin
			host_master_model_inst.xbyte(p, 1'b1, r, a);
			if (rd) begin
				host_master_model_inst.start();
				host_master_model_inst.xbyte({dev, 1'b1}, 1'b1, r, a);
				host_master_model_inst.xbyte(8'h00FF, 1'b1, r, a);
				chkByte(r, model(p));
			end else begin
				host_master_model_inst.xbyte(d, 1'b1, r, a);
				chkAck(a, 1'b1);
				if (p == host_port_pkg::REG_PROC_MAP) procMap = d;
				if (p == host_port_pkg::REG_SCRATCH) scratch = d;
			end
		end
		host_master_model_inst.stop();
	endtask

	task automatic results();
		$display("Compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========================================
	// Sequence
	initial begin
		void'($urandom(32'he216_792e));
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		repeat (3) @(negedge ref_clk);
		access(7'h40, host_port_pkg::REG_REVISION, 8'h0000, 1'b1);
		access(7'h40, host_port_pkg::REG_PROC_MAP, 8'h0040, 1'b0);
		access(7'h40, host_port_pkg::REG_PROC_MAP, 8'h0000, 1'b1);
		chkByte(processor_map_address, procMap[7:0]);
		rv = $urandom;
		access(7'h40, host_port_pkg::REG_SCRATCH, rv[7:0], 1'b0);
		access(7'h40, host_port_pkg::REG_SCRATCH, 8'h0000, 1'b1);
		host_master_model_inst.start();
		host_master_model_inst.xbyte({7'h40, 1'b0}, 1'b1, r, a);
		host_master_model_inst.xbyte(host_port_pkg::REG_PROC_MAP, 1'b1, r, a);
		host_master_model_inst.start();
		host_master_model_inst.xbyte({7'h40, 1'b1}, 1'b1, r, a);
		host_master_model_inst.xbyte(8'h00FF, 1'b0, r, a);
		chkByte(r, model(host_port_pkg::REG_PROC_MAP));
		host_master_model_inst.xbyte(8'h00FF, 1'b1, r, a);
		chkByte(r, model(host_port_pkg::REG_SCRATCH));
		host_master_model_inst.stop();
		access(7'h40, 8'h0010, 8'h0000, 1'b1);
		address_low_bit_pin = 1'b1;
		access(7'h40, host_port_pkg::REG_REVISION, 8'h0000, 1'b1);
		access(7'h41, host_port_pkg::REG_REVISION, 8'h0000, 1'b1);
		portSelect_n = 1'b1;
		access(7'h41, host_port_pkg::REG_SCRATCH, 8'h0011, 1'b0);
		portSelect_n = 1'b0;
		hwReset_n = 1'b0;
		access(7'h41, host_port_pkg::REG_SCRATCH, 8'h0022, 1'b0);
		repeat (RESET_PULSE) @(negedge ref_clk);
		hwReset_n = 1'b1;
		procMap = 0;
		scratch = 0;
		repeat (5) @(negedge ref_clk);
		chkByte(processor_map_address, 8'h0000);
		access(7'h41, host_port_pkg::REG_PROC_MAP, 8'h0000, 1'b1);
		access(7'h41, host_port_pkg::REG_SCRATCH, 8'h0000, 1'b1);
		results();
	end

	initial begin
		repeat (100000) @(posedge ref_clk);
		bad_count++;
		results();
	end
endmodule

`default_nettype wire
